// ===== hw/scb_cfg.svh
// Constants for the soft command and boost control register block
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
`define SCB_SEL_MSB 15
`define SCB_SEL_LSB 13
`define SCB_SEL_SOFT 3'h4
`define SCB_SEL_BOOST 3'h3
`define SCB_TOGGLE_BIT 12
`define SCB_CODE_MSB 11
`define SCB_CODE_RESET 12'h555
`define SCB_CODE_SERVICE 12'h195
`define SCB_STATUS_TOGGLE_BIT 11
`define SCB_COMP_BIT 6
`define SCB_PHASE_MSB 5
`define SCB_PHASE_LSB 4
`define SCB_FREQ_MSB 3
`define SCB_FREQ_LSB 2
`define SCB_VLIM_MSB 1
`define SCB_VLIM_LSB 0
`define SCB_COMP_RST 1'h0
`define SCB_PHASE_RST 2'h0
`define SCB_FREQ_RST 2'h1
`define SCB_VLIM_RST 2'h0
`define SCB_RESET_PULSE_CYC 4'h4
`endif

// ===== hw/scb_pkg.sv
// Types for the soft command and boost control register block
package scb_pkg;
   typedef enum logic [1:0]
   {
      SCB_PH_SAME = 2'h0,
      SCB_PH_AB_CD = 2'h1,
      SCB_PH_AC_BD = 2'h2,
      SCB_PH_QUAD = 2'h3
   } scb_phase_t;

   typedef enum logic [1:0]
   {
      SCB_FQ_250K = 2'h0,
      SCB_FQ_410K = 2'h1,
      SCB_FQ_650K = 2'h2,
      SCB_FQ_RSVD = 2'h3
   } scb_freq_t;

   typedef enum logic [1:0]
   {
      SCB_VL_23V0 = 2'h0,
      SCB_VL_24V5 = 2'h1,
      SCB_VL_27V0 = 2'h2,
      SCB_VL_29V5 = 2'h3
   } scb_vlimit_t;

   typedef struct packed
   {
      logic boost_comp_select;
      scb_phase_t boost_phase_select;
      scb_freq_t boost_freq_select;
      scb_vlimit_t boost_vlimit_select;
   } scb_boost_t;

   typedef enum logic [1:0]
   {
      SCB_ST_RUN = 2'h1,
      SCB_ST_RESET = 2'h2
   } scb_state_t;

   typedef struct packed
   {
      scb_state_t fsm;
      scb_boost_t boost;
      logic user_toggle;
      logic [31:0] wd_count;
      logic wd_fault;
      logic [3:0] rst_count;
   } scb_regs_t;
endpackage

// ===== hw/scb_soft_command_and_boost_ctrl_regs.sv
// Soft command and boost converter control register decode and action logic
`timescale 1ns/1ps
module scb_soft_command_and_boost_ctrl_regs
#(
   parameter int unsigned WD_TIMEOUT_CYC = 625000
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wr_valid_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wd_enable_i,
   output logic [15:0] status_o,
   output scb_pkg::scb_boost_t boost_o,
   output logic soft_reset_o,
   output logic alert_o,
   output logic wd_fault_o
);
`include "scb_cfg.svh"

   // ==========================================================
   // State
   scb_pkg::scb_regs_t r;
   scb_pkg::scb_regs_t next_r;
   logic sel_soft;
   logic sel_boost;
   logic [11:0] code;
   scb_pkg::scb_boost_t boost_rst;

   assign sel_soft = wr_valid_i && (wr_data_i[`SCB_SEL_MSB:`SCB_SEL_LSB] == `SCB_SEL_SOFT);
   assign sel_boost = wr_valid_i && (wr_data_i[`SCB_SEL_MSB:`SCB_SEL_LSB] == `SCB_SEL_BOOST);
   assign code = wr_data_i[`SCB_CODE_MSB:0];

   // ==========================================================
   // Next state
   always_comb
   begin
      boost_rst.boost_comp_select = `SCB_COMP_RST;
      boost_rst.boost_phase_select = scb_pkg::scb_phase_t'(`SCB_PHASE_RST);
      boost_rst.boost_freq_select = scb_pkg::scb_freq_t'(`SCB_FREQ_RST);
      boost_rst.boost_vlimit_select = scb_pkg::scb_vlimit_t'(`SCB_VLIM_RST);
      next_r = r;
      case (r.fsm)
         scb_pkg::SCB_ST_RUN:
         begin
            if (wd_enable_i && !r.wd_fault)
            begin
               if (r.wd_count >= WD_TIMEOUT_CYC - 1)
               begin
                  next_r.wd_fault = 1'b1;
               end
               else
               begin
                  next_r.wd_count = r.wd_count + 32'h1;
               end
            end
            else if (!wd_enable_i)
            begin
               next_r.wd_count = 32'h0;
            end
            if (sel_boost)
            begin
               next_r.boost.boost_comp_select = wr_data_i[`SCB_COMP_BIT];
               next_r.boost.boost_phase_select =
                  scb_pkg::scb_phase_t'(wr_data_i[`SCB_PHASE_MSB:`SCB_PHASE_LSB]);
               next_r.boost.boost_freq_select =
                  scb_pkg::scb_freq_t'(wr_data_i[`SCB_FREQ_MSB:`SCB_FREQ_LSB]);
               next_r.boost.boost_vlimit_select =
                  scb_pkg::scb_vlimit_t'(wr_data_i[`SCB_VLIM_MSB:`SCB_VLIM_LSB]);
            end
            if (sel_soft)
            begin
               next_r.user_toggle = wr_data_i[`SCB_TOGGLE_BIT];
               if (code == `SCB_CODE_RESET)
               begin
                  next_r.fsm = scb_pkg::SCB_ST_RESET;
                  next_r.boost = boost_rst;
                  next_r.user_toggle = 1'b0;
                  next_r.wd_count = 32'h0;
                  next_r.wd_fault = 1'b0;
                  next_r.rst_count = `SCB_RESET_PULSE_CYC;
               end
               else if (code == `SCB_CODE_SERVICE)
               begin
                  next_r.wd_count = 32'h0;
                  next_r.wd_fault = 1'b0;
               end
            end
         end
         scb_pkg::SCB_ST_RESET:
         begin
            next_r.rst_count = r.rst_count - 4'h1;
            if (r.rst_count == 4'h1)
            begin
               next_r.fsm = scb_pkg::SCB_ST_RUN;
            end
         end
         default:
         begin
            next_r.fsm = scb_pkg::SCB_ST_RUN;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         r.fsm <= scb_pkg::SCB_ST_RUN;
         r.boost.boost_comp_select <= `SCB_COMP_RST;
         r.boost.boost_phase_select <= scb_pkg::scb_phase_t'(`SCB_PHASE_RST);
         r.boost.boost_freq_select <= scb_pkg::scb_freq_t'(`SCB_FREQ_RST);
         r.boost.boost_vlimit_select <= scb_pkg::scb_vlimit_t'(`SCB_VLIM_RST);
         r.user_toggle <= 1'b0;
         r.wd_count <= 32'h0;
         r.wd_fault <= 1'b0;
         r.rst_count <= 4'h0;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs
   always_comb
   begin
      status_o = 16'h0;
      status_o[`SCB_STATUS_TOGGLE_BIT] = r.user_toggle;
   end
   assign boost_o = r.boost;
   assign soft_reset_o = (r.fsm == scb_pkg::SCB_ST_RESET);
   assign wd_fault_o = r.wd_fault;
   assign alert_o = r.wd_fault;

   // ==========================================================
   // Checks
   property p_toggle_mirror;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code != `SCB_CODE_RESET)
      |=> (status_o[`SCB_STATUS_TOGGLE_BIT] == $past(wr_data_i[`SCB_TOGGLE_BIT]));
   endproperty
   a_toggle_mirror: assert property (p_toggle_mirror) else $error("toggle not mirrored");

   property p_soft_reset;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code == `SCB_CODE_RESET) |=> soft_reset_o [*4] ##1 !soft_reset_o;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse wrong");

   property p_service_clears;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code == `SCB_CODE_SERVICE) |=> !alert_o;
   endproperty
   a_service_clears: assert property (p_service_clears) else $error("service did not clear alert");

   property p_alert_cause;
      @(posedge clk_i) disable iff (!reset_n_i)
      $rose(alert_o) |-> $past(wd_enable_i) && $past(r.wd_count) == WD_TIMEOUT_CYC - 1;
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without timeout");

   property p_boost_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_boost && r.fsm == scb_pkg::SCB_ST_RUN) |=> boost_o == $past(wr_data_i[6:0]);
   endproperty
   a_boost_write: assert property (p_boost_write) else $error("boost write lost");

   property p_defaults_after_reset;
      @(posedge clk_i) disable iff (!reset_n_i)
      $rose(soft_reset_o) |-> boost_o == 7'h04 && !status_o[`SCB_STATUS_TOGGLE_BIT];
   endproperty
   a_defaults_after_reset: assert property (p_defaults_after_reset) else $error("defaults not restored");

   property p_boost_stable;
      @(posedge clk_i) disable iff (!reset_n_i)
      (!sel_boost && !soft_reset_o && !$rose(soft_reset_o)) |=> $stable(boost_o) || soft_reset_o;
   endproperty
   a_boost_stable: assert property (p_boost_stable) else $error("boost changed without write");

   property p_status_readonly;
      @(posedge clk_i) disable iff (!reset_n_i)
      !sel_soft |=> $stable(status_o);
   endproperty
   a_status_readonly: assert property (p_status_readonly) else $error("status changed without soft write");

   property p_reset_count_load;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code == `SCB_CODE_RESET)
      |=> r.rst_count == `SCB_RESET_PULSE_CYC;
   endproperty
   a_reset_count_load: assert property (p_reset_count_load) else $error("reset pulse count not loaded");

   property p_reset_count_range;
      @(posedge clk_i) disable iff (!reset_n_i)
      soft_reset_o
      |-> r.rst_count != 4'h0 && r.rst_count <= `SCB_RESET_PULSE_CYC;
   endproperty
   a_reset_count_range: assert property (p_reset_count_range) else $error("reset pulse count out of range");

   property p_write_ignored_in_reset;
      @(posedge clk_i) disable iff (!reset_n_i)
      (wr_valid_i && soft_reset_o)
      |=> $stable(boost_o) && $stable(status_o);
   endproperty
   a_write_ignored_in_reset: assert property (p_write_ignored_in_reset) else $error("write taken during reset");

   property p_other_code_no_reset;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code != `SCB_CODE_RESET)
      |=> !soft_reset_o;
   endproperty
   a_other_code_no_reset: assert property (p_other_code_no_reset) else $error("reset from other code");

   property p_soft_keeps_boost;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code != `SCB_CODE_RESET)
      |=> $stable(boost_o);
   endproperty
   a_soft_keeps_boost: assert property (p_soft_keeps_boost) else $error("boost changed by soft command");

   property p_other_code_keeps_fault;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && alert_o
         && code != `SCB_CODE_RESET && code != `SCB_CODE_SERVICE)
      |=> alert_o;
   endproperty
   a_other_code_keeps_fault: assert property (p_other_code_keeps_fault) else $error("fault cleared by other code");

   property p_status_spare_zero;
      @(posedge clk_i) disable iff (!reset_n_i)
      (status_o & ~(16'h1 << `SCB_STATUS_TOGGLE_BIT)) == 16'h0;
   endproperty
   a_status_spare_zero: assert property (p_status_spare_zero) else $error("spare status bit set");

   property p_soft_reset_defaults;
      @(posedge clk_i) disable iff (!reset_n_i)
      soft_reset_o
      |-> boost_o == {`SCB_COMP_RST, `SCB_PHASE_RST, `SCB_FREQ_RST, `SCB_VLIM_RST}
         && status_o == 16'h0 && !alert_o;
   endproperty
   a_soft_reset_defaults: assert property (p_soft_reset_defaults) else $error("defaults lost during reset");

   // ==========================================================
   // Watchdog checks
   property p_wd_hold_disabled;
      @(posedge clk_i) disable iff (!reset_n_i)
      !wd_enable_i
      |=> r.wd_count == 32'h0;
   endproperty
   a_wd_hold_disabled: assert property (p_wd_hold_disabled) else $error("watchdog counts while off");

   property p_service_restarts;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_soft && r.fsm == scb_pkg::SCB_ST_RUN && code == `SCB_CODE_SERVICE)
      |=> r.wd_count == 32'h0;
   endproperty
   a_service_restarts: assert property (p_service_restarts) else $error("service did not restart count");

   property p_wd_count_step;
      @(posedge clk_i) disable iff (!reset_n_i)
      (r.fsm == scb_pkg::SCB_ST_RUN && wd_enable_i && !r.wd_fault && !sel_soft
         && r.wd_count < WD_TIMEOUT_CYC - 1)
      |=> r.wd_count == $past(r.wd_count) + 32'h1;
   endproperty
   a_wd_count_step: assert property (p_wd_count_step) else $error("watchdog count step wrong");

   property p_fault_on_timeout;
      @(posedge clk_i) disable iff (!reset_n_i)
      (r.fsm == scb_pkg::SCB_ST_RUN && wd_enable_i && !r.wd_fault && !sel_soft
         && r.wd_count >= WD_TIMEOUT_CYC - 1)
      |=> alert_o;
   endproperty
   a_fault_on_timeout: assert property (p_fault_on_timeout) else $error("timeout without alert");

   property p_fault_sticky;
      @(posedge clk_i) disable iff (!reset_n_i)
      (alert_o && !sel_soft)
      |=> alert_o;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("alert dropped without service");

   // ==========================================================
   // Boost field checks
   property p_comp_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_boost && r.fsm == scb_pkg::SCB_ST_RUN)
      |=> boost_o.boost_comp_select == $past(wr_data_i[`SCB_COMP_BIT]);
   endproperty
   a_comp_write: assert property (p_comp_write) else $error("compensation select lost");

   property p_phase_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_boost && r.fsm == scb_pkg::SCB_ST_RUN)
      |=> boost_o.boost_phase_select == $past(wr_data_i[`SCB_PHASE_MSB:`SCB_PHASE_LSB]);
   endproperty
   a_phase_write: assert property (p_phase_write) else $error("phase select lost");

   property p_freq_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_boost && r.fsm == scb_pkg::SCB_ST_RUN)
      |=> boost_o.boost_freq_select == $past(wr_data_i[`SCB_FREQ_MSB:`SCB_FREQ_LSB]);
   endproperty
   a_freq_write: assert property (p_freq_write) else $error("frequency select lost");

   property p_vlim_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (sel_boost && r.fsm == scb_pkg::SCB_ST_RUN)
      |=> boost_o.boost_vlimit_select == $past(wr_data_i[`SCB_VLIM_MSB:`SCB_VLIM_LSB]);
   endproperty
   a_vlim_write: assert property (p_vlim_write) else $error("voltage limit select lost");
endmodule

// ===== tb/scb_host_model.sv
// Host model that delivers decoded register words to the block
`timescale 1ns/1ps
module scb_host_model
(
   input wire logic clk_i,
   output logic wr_valid_o,
   output logic [15:0] wr_data_o
);
   initial
   begin
      wr_valid_o = 1'b0;
      wr_data_o = 16'h0000;
   end
   // ==========================================
   // One word per pulse, data flipped when idle
   task automatic send(input logic [15:0] w);
      @(posedge clk_i);
      wr_valid_o <= 1'b1;
      wr_data_o <= w;
      @(posedge clk_i);
      wr_valid_o <= 1'b0;
      wr_data_o <= ~w;
   endtask
   // Watchdog service word
   task automatic service(input logic t);
      send({3'h4, t, 12'h195});
   endtask
endmodule

// ===== tb/scb_soft_command_and_boost_ctrl_regs_test.sv
// Testbench for the soft command and boost control register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module scb_soft_command_and_boost_ctrl_regs_test;
   logic clk_i;
   logic reset_n_i;
   logic wr_valid;
   logic [15:0] wr_data;
   logic wd_enable_i;
   logic [15:0] status_o;
   scb_pkg::scb_boost_t boost_o;
   logic soft_reset_o;
   logic alert_o;
   logic wd_fault_o;
   logic [6:0] e;
   int err_total = 0;
   int n_compared = 0;
   int i;
   scb_host_model host_u (.clk_i(clk_i), .wr_valid_o(wr_valid), .wr_data_o(wr_data));
   scb_soft_command_and_boost_ctrl_regs #(.WD_TIMEOUT_CYC(16)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wd_enable_i(wd_enable_i), .status_o(status_o),
      .boost_o(boost_o), .soft_reset_o(soft_reset_o), .alert_o(alert_o), .wd_fault_o(wd_fault_o));
   // ==========================================
   // Clock and hang guard
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      close_out();
   end
   // ==========================================
   // Helpers
   task automatic wr(input logic [15:0] w);
      host_u.send(w);
      @(negedge clk_i);
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      reset_n_i = 1'b0;
      wd_enable_i = 1'b0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(negedge clk_i);
      `CHK("boost_o", 7'h04, boost_o)
      `CHK("status_o", 16'h0000, status_o)
      `CHK("alert_o", 1'b0, alert_o)
      for (i = 0; i < 4; i++)
      begin
         e = {i[0], i[1:0], 2'(i % 3), 2'(3 - i)};
         wr({3'h3, 6'h2a ^ 6'(i), e});
         `CHK("boost_o", e, boost_o)
         `CHK("status_o", 16'h0000, status_o)
      end
      wr(16'ha555);
      `CHK("soft_reset_o", 1'b0, soft_reset_o)
      `CHK("boost_o", e, boost_o)
      wr(16'h9123);
      `CHK("status_o", 16'h0800, status_o)
      `CHK("boost_o", e, boost_o)
      wr(16'h8abc);
      `CHK("status_o", 16'h0000, status_o)
      wr(16'h9555);
      `CHK("soft_reset_o", 1'b1, soft_reset_o)
      `CHK("boost_o", 7'h04, boost_o)
      `CHK("status_o", 16'h0000, status_o)
      wr(16'h607f);
      `CHK("boost_o", 7'h04, boost_o)
      @(negedge clk_i);
      `CHK("soft_reset_o", 1'b1, soft_reset_o)
      @(negedge clk_i);
      `CHK("soft_reset_o", 1'b0, soft_reset_o)
      @(posedge clk_i);
      wd_enable_i <= 1'b1;
      repeat (8) @(negedge clk_i);
      `CHK("alert_o", 1'b0, alert_o)
      for (i = 0; i < 40 && alert_o !== 1'b1; i++) @(negedge clk_i);
      if (i == 40)
      begin
         err_total++;
         close_out();
      end
      `CHK("wd_fault_o", 1'b1, wd_fault_o)
      wr(16'h8abc);
      `CHK("alert_o", 1'b1, alert_o)
      `CHK("status_o", 16'h0000, status_o)
      host_u.service(1'b1);
      @(negedge clk_i);
      `CHK("alert_o", 1'b0, alert_o)
      `CHK("status_o", 16'h0800, status_o)
      @(posedge clk_i);
      wd_enable_i <= 1'b0;
      repeat (40) @(negedge clk_i);
      `CHK("alert_o", 1'b0, alert_o)
      wr(16'h605a);
      `CHK("boost_o", 7'h5a, boost_o)
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(negedge clk_i);
      `CHK("boost_o", 7'h04, boost_o)
      `CHK("status_o", 16'h0000, status_o)
      wr(16'h6075);
      `CHK("boost_o", 7'h75, boost_o)
      close_out();
   end
endmodule
